// ==== srlc_pkg.sv ====
// shared constants and types of the serial radio link block
package srlc_pkg;

  // ==========================================================================
  // clock and line rates
  localparam int CLK_HZ           = 200_000_000;
  localparam int BAUD_DEFAULT_BPS = 57600;
  localparam int RF_RATE_BPS      = 76800;
  localparam int RF_BITS_PER_BYTE = 10;
  localparam logic [15:0] BAUD_DIV_DEFAULT = 16'(CLK_HZ / BAUD_DEFAULT_BPS);
  localparam int RF_BYTE_CYCLES_DEFAULT =
    (CLK_HZ / RF_RATE_BPS) * RF_BITS_PER_BYTE;
  localparam int ACK_WAIT_CYCLES_DEFAULT  = 4 * RF_BYTE_CYCLES_DEFAULT;
  localparam int BACKOFF_SLOT_DEFAULT     = RF_BYTE_CYCLES_DEFAULT;

  // ==========================================================================
  // field limits and reset values
  localparam logic [7:0]  CHAN_MIN       = 8'h10;
  localparam logic [7:0]  CHAN_MAX       = 8'h2F;
  localparam logic [7:0]  COUNT_MIN      = 8'h02;
  localparam logic [7:0]  COUNT_DEFAULT  = 8'h04;
  localparam logic [47:0] MAC_ALL        = 48'hFFFF_FFFF_FFFF;
  localparam logic [15:0] LFSR_SEED      = 16'hACE1;
  localparam logic [1:0]  DLV_CODE_BCAST = 2'h0;
  localparam logic [1:0]  DLV_CODE_AUTO  = 2'h1;
  localparam int          TIMER_W        = 24;

  // ==========================================================================
  // delivery mode, exactly one active
  typedef enum logic [2:0] {
    DLV_BCAST = 3'b001,
    DLV_AUTO  = 3'b010,
    DLV_ADDR  = 3'b100
  } srlc_dlv_e;

  // radio transmit sequencer
  typedef enum logic [4:0] {
    TX_IDLE    = 5'b00001,
    TX_SEND    = 5'b00010,
    TX_ACKWAIT = 5'b00100,
    TX_BACKOFF = 5'b01000,
    TX_GAP     = 5'b10000
  } srlc_tx_e;

endpackage

// ==== srlc_top.sv ====
// serial and packet delivery control, host port to radio
`timescale 1ns/100ps

// Notes on behaviour
// R1: bus mode forwards every host byte to radio, no address filter
// R2: radio packets go out on the bus at once
// R3: half duplex bus: drive only while sending
// R4: clear-to-send is high whenever a byte can be taken
// R5: send to host only while its rts input is low
// R6: rts high holds off all host output until low again
// R7: cts is active by default, whatever the rts option
// R8: bus mode has no rts or cts throttling
// R9: flow control stays local, never sent by radio
// R10: serial rate is configurable, reset default 57600 bit/s
// R11: host runs its port at the configured rate
// R12: radio pacing fixed at 76.8 kbit/s, whatever the serial rate
// R13: after a collision, wait a random back-off of set spread; code backs off only on a collision seen in TX_ACKWAIT
// R14: channel numbers 16 to 47 only; others block the radio
// R15: count unacknowledged sends, drop at max (default 4, 2..255)
// R16: broadcast sends each packet the set number of times, no ack
// R17: exchange only with units of equal channel and network identifier
// R18: encryption ciphers payload with the 56-bit key; wrong key garbles
// R19: own unique 6-byte address names the device
// R20: a set destination address requests radio acks
// R21: broadcast delivery addresses all units on the network
// R22: auto mode learns its destination from the first received source
// R23: addressed mode talks only to the configured destination
// R24: broadcast, auto, addressed delivery: exactly one active
module srlc_top #(
  parameter int RF_BYTE_CYCLES  = srlc_pkg::RF_BYTE_CYCLES_DEFAULT,
  parameter int ACK_WAIT_CYCLES = srlc_pkg::ACK_WAIT_CYCLES_DEFAULT,
  parameter int BACKOFF_SLOT    = srlc_pkg::BACKOFF_SLOT_DEFAULT
) (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  // configuration
  input  wire logic        i_bus_mode,
  input  wire logic        i_rts_enable,
  input  wire logic        i_baud_load,
  input  wire logic [15:0] i_baud_div,
  input  wire logic [7:0]  i_backoff_spread,
  input  wire logic [7:0]  i_channel,
  input  wire logic [7:0]  i_network_identifier,
  input  wire logic [7:0]  i_max_retries,
  input  wire logic [7:0]  i_bcast_attempts,
  input  wire logic        i_crypt_en,
  input  wire logic [55:0] i_crypt_key,
  input  wire logic [47:0] i_own_mac,
  input  wire logic [47:0] i_dest_mac,
  input  wire logic [1:0]  i_delivery,
  // host pins and serial byte streams
  input  wire logic        i_host_rts,
  output logic             o_host_cts,
  output logic             o_baud_tick,
  input  wire logic        i_host_rx_valid,
  input  wire logic [7:0]  i_host_rx_data,
  output logic             o_host_rx_ready,
  output logic             o_host_tx_valid,
  output logic [7:0]       o_host_tx_data,
  input  wire logic        i_host_tx_ready,
  output logic             o_bus_drive,
  // radio transmit side
  output logic             o_rf_tx_valid,
  output logic [7:0]       o_rf_tx_data,
  output logic [47:0]      o_rf_tx_dest,
  output logic [47:0]      o_rf_tx_src,
  output logic [7:0]       o_rf_tx_chan,
  output logic [7:0]       o_rf_tx_netid,
  output logic             o_rf_tx_ack_req,
  input  wire logic        i_rf_tx_ready,
  input  wire logic        i_rf_ack,
  input  wire logic        i_rf_collision,
  output logic             o_rf_done,
  output logic             o_rf_drop,
  // radio receive side
  input  wire logic        i_rf_rx_valid,
  input  wire logic [7:0]  i_rf_rx_data,
  input  wire logic [47:0] i_rf_rx_src,
  input  wire logic [47:0] i_rf_rx_dst,
  input  wire logic [7:0]  i_rf_rx_chan,
  input  wire logic [7:0]  i_rf_rx_netid,
  output logic             o_rf_rx_ready,
  // status
  output logic             o_chan_invalid,
  output logic             o_dest_learned
);

  // ==========================================================================
  // helper functions
  // clamp a count to 2..255
  function automatic logic [7:0] clamp_count(input logic [7:0] v);
    clamp_count = (v < srlc_pkg::COUNT_MIN) ? srlc_pkg::COUNT_MIN : v;
  endfunction

  // fold the key into one keystream byte
  function automatic logic [7:0] key_byte(input logic [55:0] k, input logic [2:0] idx);
    logic [7:0] acc;
    acc = 8'h00;
    for (int n = 0; n < 7; n++) begin
      acc = acc ^ k[n*8 +: 8];
    end
    key_byte = acc ^ k[(32'(idx) % 7) * 8 +: 8];
  endfunction

  // ==========================================================================
  // rts pin synchroniser
  logic rts_meta;
  logic rts_sync;

  always_ff @(posedge i_clk) begin
    rts_meta <= i_host_rts;
    rts_sync <= rts_meta;
  end

  // ==========================================================================
  // serial rate divider
  logic [15:0] baud_div;
  logic [15:0] baud_cnt;
  wire         baud_wrap = (baud_cnt >= baud_div - 16'h0001);

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      baud_div    <= srlc_pkg::BAUD_DIV_DEFAULT; // [R10]
      baud_cnt    <= 16'h0000;
      o_baud_tick <= 1'b0;
    end else begin
      if (i_baud_load) begin
        baud_div <= (i_baud_div == 16'h0000) ? 16'h0001 : i_baud_div; // [R10]
      end
      baud_cnt    <= baud_wrap ? 16'h0000 : baud_cnt + 16'h0001;
      o_baud_tick <= baud_wrap;
    end
  end

  // ==========================================================================
  // configuration decode
  wire srlc_pkg::srlc_dlv_e dlv =
    (i_delivery == srlc_pkg::DLV_CODE_BCAST) ? srlc_pkg::DLV_BCAST :
    (i_delivery == srlc_pkg::DLV_CODE_AUTO)  ? srlc_pkg::DLV_AUTO  :
                                               srlc_pkg::DLV_ADDR; // [R24]
  wire       chan_ok   = (i_channel >= srlc_pkg::CHAN_MIN) &&
                         (i_channel <= srlc_pkg::CHAN_MAX); // [R14]
  wire [7:0] max_tries = clamp_count(i_max_retries);    // [R15]
  wire [7:0] max_bcast = clamp_count(i_bcast_attempts); // [R16]
  wire       is_bcast  = (dlv == srlc_pkg::DLV_BCAST);
  logic [47:0] learned_mac;
  logic        learned;
  wire [47:0] dest_sel =
    is_bcast                      ? srlc_pkg::MAC_ALL : // [R21]
    (dlv == srlc_pkg::DLV_AUTO)   ? (learned ? learned_mac : srlc_pkg::MAC_ALL) :
                                    i_dest_mac;         // [R23]
  wire need_ack = !is_bcast && (dest_sel != srlc_pkg::MAC_ALL); // [R20]

  // ==========================================================================
  // two-entry host-to-radio buffer
  logic [7:0] buf_mem [0:1];
  logic       buf_wptr;
  logic       buf_rptr;
  logic [1:0] buf_cnt;
  logic       buf_pop;
  // all bus bytes are taken, no address check
  wire        buf_push   = i_host_rx_valid && o_host_rx_ready; // [R1]
  wire [1:0]  next_cnt   = buf_cnt + {1'b0, buf_push} - {1'b0, buf_pop};
  wire        buf_valid  = (buf_cnt != 2'h0);
  wire [7:0]  buf_head   = buf_mem[buf_rptr];

  always_ff @(posedge i_clk) begin
    if (buf_push) begin
      buf_mem[buf_wptr] <= i_host_rx_data;
    end
  end

  // buffer pointers, readiness and clear-to-send
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      buf_wptr        <= 1'b0;
      buf_rptr        <= 1'b0;
      buf_cnt         <= 2'h0;
      o_host_rx_ready <= 1'b1;
      o_host_cts      <= 1'b1; // [R7]
    end else begin
      buf_wptr        <= buf_wptr ^ buf_push;
      buf_rptr        <= buf_rptr ^ buf_pop;
      buf_cnt         <= next_cnt;
      o_host_rx_ready <= (next_cnt != 2'h2);
      // cts follows buffer room, except in bus mode
      o_host_cts      <= i_bus_mode || (next_cnt != 2'h2); // [R4] [R7] [R8] [R9]
    end
  end

  // ==========================================================================
  // random source for collision back-off
  logic [15:0] lfsr;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      lfsr <= srlc_pkg::LFSR_SEED;
    end else begin
      lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    end
  end

  // ==========================================================================
  // radio transmit sequencer
  localparam int TIMER_W = srlc_pkg::TIMER_W;
  srlc_pkg::srlc_tx_e tx_st;
  srlc_pkg::srlc_tx_e next_tx_st;
  logic [7:0]         tries;
  logic [TIMER_W-1:0] timer;
  logic [7:0]         slots;
  logic               resend;
  logic [2:0]         key_idx;

  wire timer_done = (timer == '0);
  wire sent       = (tx_st == srlc_pkg::TX_SEND) && o_rf_tx_valid && i_rf_tx_ready;
  wire next_tries_hit = ((tries + 8'h01) >= (is_bcast ? max_bcast : max_tries));
  wire ack_timeout    = (tx_st == srlc_pkg::TX_ACKWAIT) && timer_done && !i_rf_ack;
  wire collide        = (tx_st == srlc_pkg::TX_ACKWAIT) && i_rf_collision && !i_rf_ack;
  wire give_up        = ack_timeout && (tries >= max_tries); // [R15]
  wire bcast_last     = sent && is_bcast && next_tries_hit;  // [R16]
  wire acked          = (tx_st == srlc_pkg::TX_ACKWAIT) && i_rf_ack;

  assign buf_pop = acked || give_up || bcast_last ||
                   (sent && !is_bcast && !need_ack);

  // next state of the sequencer
  always_comb begin
    next_tx_st = tx_st;
    case (tx_st)
      srlc_pkg::TX_IDLE: begin
        if (buf_valid && chan_ok) begin // [R14]
          next_tx_st = srlc_pkg::TX_SEND;
        end
      end
      srlc_pkg::TX_SEND: begin
        if (sent) begin
          next_tx_st = (need_ack && !is_bcast) ? srlc_pkg::TX_ACKWAIT : srlc_pkg::TX_GAP;
        end
      end
      srlc_pkg::TX_ACKWAIT: begin
        if (acked || ack_timeout) begin
          next_tx_st = srlc_pkg::TX_GAP;
        end else if (collide) begin
          next_tx_st = srlc_pkg::TX_BACKOFF; // [R13]
        end
      end
      srlc_pkg::TX_BACKOFF: begin
        if (timer_done && slots == 8'h00) begin
          next_tx_st = srlc_pkg::TX_SEND;
        end
      end
      srlc_pkg::TX_GAP: begin
        if (timer_done) begin
          next_tx_st = resend ? srlc_pkg::TX_SEND : srlc_pkg::TX_IDLE;
        end
      end
      default: begin
        next_tx_st = srlc_pkg::TX_IDLE;
      end
    endcase
  end

  // state, attempt count and resend flag
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      tx_st  <= srlc_pkg::TX_IDLE;
      tries  <= 8'h00;
      resend <= 1'b0;
    end else begin
      tx_st <= next_tx_st;
      if (tx_st == srlc_pkg::TX_IDLE) begin
        tries <= 8'h00;
      end else if (sent) begin
        tries <= tries + 8'h01; // [R15] [R16]
      end
      if (sent) begin
        resend <= is_bcast && !next_tries_hit; // [R16]
      end else if (ack_timeout) begin
        resend <= !give_up; // [R15]
      end else if (acked) begin
        resend <= 1'b0;
      end
    end
  end

  // pacing, ack wait and back-off timer
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      timer <= '0;
      slots <= 8'h00;
    end else if (sent) begin
      timer <= need_ack && !is_bcast ? TIMER_W'(ACK_WAIT_CYCLES) :
                                       TIMER_W'(RF_BYTE_CYCLES); // [R12]
    end else if (collide) begin
      timer <= TIMER_W'(BACKOFF_SLOT);
      slots <= lfsr[7:0] & i_backoff_spread; // [R13]
    end else if (acked || ack_timeout) begin
      timer <= TIMER_W'(RF_BYTE_CYCLES); // [R12]
    end else if (!timer_done) begin
      timer <= timer - TIMER_W'(1);
    end else if (tx_st == srlc_pkg::TX_BACKOFF && slots != 8'h00) begin
      timer <= TIMER_W'(BACKOFF_SLOT); // [R13]
      slots <= slots - 8'h01;
    end
  end

  // radio frame outputs, ciphered if enabled
  wire [7:0] tx_plain = buf_head;
  wire [7:0] tx_byte  = i_crypt_en ? (tx_plain ^ key_byte(i_crypt_key, key_idx)) :
                                     tx_plain; // [R18]

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_rf_tx_valid   <= 1'b0;
      o_rf_tx_data    <= 8'h00;
      o_rf_tx_dest    <= srlc_pkg::MAC_ALL;
      o_rf_tx_src     <= 48'h0000_0000_0000;
      o_rf_tx_chan    <= 8'h00;
      o_rf_tx_netid   <= 8'h00;
      o_rf_tx_ack_req <= 1'b0;
      o_rf_done       <= 1'b0;
      o_rf_drop       <= 1'b0;
      key_idx         <= 3'h0;
    end else begin
      o_rf_tx_valid   <= (next_tx_st == srlc_pkg::TX_SEND) && !sent;
      o_rf_tx_data    <= tx_byte;
      o_rf_tx_dest    <= dest_sel;     // [R21] [R22] [R23]
      o_rf_tx_src     <= i_own_mac;    // [R19]
      o_rf_tx_chan    <= i_channel;    // [R17]
      o_rf_tx_netid   <= i_network_identifier; // [R17]
      o_rf_tx_ack_req <= need_ack;     // [R20]
      o_rf_done       <= acked || bcast_last || (sent && !is_bcast && !need_ack);
      o_rf_drop       <= give_up;      // [R15]
      if (buf_pop) begin
        key_idx <= key_idx + 3'h1;
      end
    end
  end

  // ==========================================================================
  // radio receive filter and destination learning
  wire rx_net_ok  = chan_ok && (i_rf_rx_chan == i_channel) &&
                    (i_rf_rx_netid == i_network_identifier); // [R17]
  wire rx_to_me   = (i_rf_rx_dst == i_own_mac) ||
                    (i_rf_rx_dst == srlc_pkg::MAC_ALL); // [R19]
  wire rx_peer_ok = (dlv == srlc_pkg::DLV_ADDR) ? (i_rf_rx_src == i_dest_mac) : // [R23]
                    (dlv == srlc_pkg::DLV_AUTO && learned) ? (i_rf_rx_src == learned_mac) :
                    1'b1;
  wire rx_take    = i_rf_rx_valid && o_rf_rx_ready;
  wire rx_keep    = rx_take && rx_net_ok && rx_to_me && rx_peer_ok;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      learned        <= 1'b0;
      learned_mac    <= srlc_pkg::MAC_ALL;
      o_dest_learned <= 1'b0;
      o_chan_invalid <= 1'b0;
    end else begin
      if (rx_keep && dlv == srlc_pkg::DLV_AUTO && !learned) begin
        learned     <= 1'b1; // [R22]
        learned_mac <= i_rf_rx_src;
      end
      o_dest_learned <= learned;
      o_chan_invalid <= !chan_ok; // [R14]
    end
  end

  // ==========================================================================
  // received byte toward host or bus
  logic       hold_valid;
  logic [7:0] hold_data;
  logic [2:0] rx_key_idx;
  wire        host_took = o_host_tx_valid && i_host_tx_ready;
  wire        next_hold = rx_keep || (hold_valid && !host_took);
  // rts gates only the serial port with flow control on
  wire        may_send  = i_bus_mode || !i_rts_enable || !rts_sync; // [R5] [R6] [R8]
  wire [7:0]  rx_plain  = i_crypt_en ?
                          (i_rf_rx_data ^ key_byte(i_crypt_key, rx_key_idx)) :
                          i_rf_rx_data; // [R18]

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      hold_valid      <= 1'b0;
      hold_data       <= 8'h00;
      rx_key_idx      <= 3'h0;
      o_rf_rx_ready   <= 1'b1;
      o_host_tx_valid <= 1'b0;
      o_host_tx_data  <= 8'h00;
      o_bus_drive     <= 1'b0;
    end else begin
      hold_valid <= next_hold;
      if (rx_keep) begin
        hold_data  <= rx_plain;
        rx_key_idx <= rx_key_idx + 3'h1;
      end
      o_rf_rx_ready   <= !next_hold;
      o_host_tx_valid <= next_hold && may_send; // [R2] [R5] [R6]
      o_host_tx_data  <= rx_keep ? rx_plain : hold_data;
      o_bus_drive     <= i_bus_mode && next_hold; // [R2] [R3]
    end
  end

endmodule

// ==== srlc_chk.sv ====
// concurrent checks on the block's ports
`timescale 1ns/100ps
module srlc_chk (
  // clock, reset, config
  input wire logic        i_clk,
  input wire logic        i_sys_rst,
  input wire logic        i_bus_mode,
  input wire logic        i_rts_enable,
  input wire logic [7:0]  i_channel,
  input wire logic [7:0]  i_network_identifier,
  input wire logic [47:0] i_own_mac,
  input wire logic [47:0] i_dest_mac,
  input wire logic [1:0]  i_delivery,
  // host side
  input wire logic        i_host_rts,
  input wire logic        o_host_cts,
  input wire logic        o_host_rx_ready,
  input wire logic        o_host_tx_valid,
  input wire logic        o_bus_drive,
  // radio side
  input wire logic        o_rf_tx_valid,
  input wire logic [7:0]  o_rf_tx_data,
  input wire logic [47:0] o_rf_tx_dest,
  input wire logic [47:0] o_rf_tx_src,
  input wire logic [7:0]  o_rf_tx_chan,
  input wire logic [7:0]  o_rf_tx_netid,
  input wire logic        o_rf_tx_ack_req,
  input wire logic        i_rf_tx_ready,
  input wire logic        i_rf_ack,
  input wire logic        o_rf_done,
  input wire logic        o_rf_drop,
  input wire logic        o_chan_invalid
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  // ==========================================================================
  // flow control and bus
  cts_bus_a: assert property (i_bus_mode && $past(i_bus_mode) |-> o_host_cts)
    else $error("cts dropped in bus mode");
  cts_full_a: assert property (!i_bus_mode && !$past(i_bus_mode) && i_rts_enable
    |-> o_host_cts == o_host_rx_ready) else $error("cts differs from room");
  rts_hold_a: assert property ((!i_bus_mode && i_rts_enable && i_host_rts)[*5]
    |-> !o_host_tx_valid) else $error("byte offered while rts high");
  bus_drive_a: assert property (o_bus_drive |-> i_bus_mode && o_host_tx_valid)
    else $error("bus driven without a pending byte");

  // ==========================================================================
  // radio offers and channel flag
  tx_hold_a: assert property (o_rf_tx_valid && !i_rf_tx_ready
    |=> o_rf_tx_valid && $stable(o_rf_tx_data)) else $error("offer withdrawn");
  chan_flag_a: assert property ($stable(i_channel) |-> o_chan_invalid ==
    (i_channel < srlc_pkg::CHAN_MIN || i_channel > srlc_pkg::CHAN_MAX))
    else $error("channel flag wrong");
  tx_tags_a: assert property (o_rf_tx_valid |-> o_rf_tx_chan == i_channel &&
    o_rf_tx_netid == i_network_identifier && o_rf_tx_src == i_own_mac)
    else $error("frame tags wrong");
  ack_dest_a: assert property (o_rf_tx_valid && i_delivery[1] &&
    i_dest_mac != srlc_pkg::MAC_ALL |-> o_rf_tx_ack_req && o_rf_tx_dest == i_dest_mac)
    else $error("addressed frame wrong");
  bcast_a: assert property (o_rf_tx_valid && i_delivery == srlc_pkg::DLV_CODE_BCAST
    |-> !o_rf_tx_ack_req && o_rf_tx_dest == srlc_pkg::MAC_ALL) else $error("bcast wrong");

  // an acked take ends in done
  sequence s_ack_take;
    o_rf_tx_valid && i_rf_tx_ready && o_rf_tx_ack_req;
  endsequence
  ack_done_a: assert property (s_ack_take ##[1:8] i_rf_ack |=> o_rf_done && !o_rf_drop)
    else $error("ack did not finish packet");
endmodule

bind srlc_top srlc_chk u_chk (.*);

// ==== srlc_host_model.sv ====
// host model on the serial port: paced byte sink with an rts pin
`timescale 1ns/100ps
module srlc_host_model (
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_sys_rst,
  // bench controls
  input  wire logic       i_pause,
  input  wire logic       i_stall,
  // device side
  input  wire logic       i_tick,
  input  wire logic       i_valid,
  input  wire logic [7:0] i_data,
  output logic            o_rts,
  output logic            o_ready,
  output logic [7:0]      o_last,
  output logic [7:0]      o_count
);
  // host only listens, never drives the shared line
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_rts   <= 1'b0;
      o_ready <= 1'b0;
      o_count <= 8'h00;
    end else begin
      o_rts   <= i_pause;
      o_ready <= i_tick && !i_stall; // takes bytes at the configured bit pace
      if (i_valid && o_ready) begin
        o_count <= o_count + 8'h01;
        o_last  <= i_data;
      end
    end
  end
endmodule

// ==== srlc_tb_top.sv ====
// self-checking testbench for the serial radio link block
`timescale 1ns/100ps
module srlc_tb_top;
  // ==========================================================================
  // signals
  logic i_clk, i_sys_rst, i_bus_mode, i_rts_enable, i_baud_load, i_crypt_en;
  logic [15:0] i_baud_div;
  logic [7:0] i_backoff_spread, i_channel, i_network_identifier, i_max_retries;
  logic [7:0] i_bcast_attempts, i_host_rx_data, o_host_tx_data, o_rf_tx_data, i_rf_rx_data;
  logic [7:0] i_rf_rx_chan, i_rf_rx_netid, o_rf_tx_chan, o_rf_tx_netid, host_last, host_cnt;
  logic [55:0] i_crypt_key;
  logic [47:0] i_own_mac, i_dest_mac, o_rf_tx_dest, o_rf_tx_src, i_rf_rx_src, i_rf_rx_dst;
  logic [47:0] dest_seen;
  logic [1:0] i_delivery;
  logic i_host_rts, o_host_cts, o_baud_tick, i_host_rx_valid, o_host_rx_ready;
  logic o_host_tx_valid, i_host_tx_ready, o_bus_drive, o_rf_tx_valid, o_rf_tx_ack_req;
  logic i_rf_tx_ready, i_rf_ack, i_rf_collision, o_rf_done, o_rf_drop, i_rf_rx_valid;
  logic o_rf_rx_ready, o_chan_invalid, o_dest_learned, host_pause, host_stall;
  logic [7:0] q [$];
  int n_mismatch, compares, n_acc, n_done, n_drop, cyc;

  srlc_host_model u_host (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_pause(host_pause),
    .i_stall(host_stall), .i_tick(o_baud_tick), .i_valid(o_host_tx_valid),
    .i_data(o_host_tx_data), .o_rts(i_host_rts), .o_ready(i_host_tx_ready),
    .o_last(host_last), .o_count(host_cnt));
  srlc_top #(.RF_BYTE_CYCLES(20), .ACK_WAIT_CYCLES(80), .BACKOFF_SLOT(10)) dut (.*);

  always #2.5 i_clk = ~i_clk;

  // radio takes, pulses and hang limit
  always @(posedge i_clk) begin
    if (o_rf_tx_valid && i_rf_tx_ready) begin
      n_acc++;
      q.push_back(o_rf_tx_data);
      dest_seen = o_rf_tx_dest;
    end
    n_done += o_rf_done;
    n_drop += o_rf_drop;
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      tally_and_finish;
    end
  end

  // ==========================================================================
  // shared tasks
  task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task automatic host_send(input logic [7:0] b);
    @(posedge i_clk);
    i_host_rx_valid <= 1'b1;
    i_host_rx_data <= b;
    do @(posedge i_clk); while (o_host_rx_ready !== 1'b1);
    i_host_rx_valid <= 1'b0;
  endtask
  task automatic rf_recv(input logic [7:0] b, input logic [47:0] src, input logic [7:0] nid);
    @(posedge i_clk);
    i_rf_rx_valid <= 1'b1;
    i_rf_rx_data <= b;
    i_rf_rx_src <= src;
    i_rf_rx_netid <= nid;
    do @(posedge i_clk); while (o_rf_rx_ready !== 1'b1);
    i_rf_rx_valid <= 1'b0;
  endtask
  task automatic tally_and_finish;
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_reset;
    int n;
    chk("cts", o_host_cts, 1);
    chk("rx ready", o_host_rx_ready, 1);
    do tick(1); while (o_baud_tick !== 1'b1);
    n = 0;
    do begin tick(1); n++; end while (o_baud_tick !== 1'b1);
    chk("baud period", n, srlc_pkg::BAUD_DIV_DEFAULT);
    i_baud_div <= 16'h0008;
    i_baud_load <= 1'b1;
    tick(1);
    i_baud_load <= 1'b0;
  endtask
  task automatic t_bcast;
    int a, d;
    a = n_acc;
    d = n_done;
    host_send(8'h3C);
    tick(150);
    chk("bcast sends", n_acc - a, 2);
    chk("bcast done", n_done - d, 1);
    chk("bcast dest", dest_seen, srlc_pkg::MAC_ALL);
    chk("host quiet", host_cnt, 8'h00);
  endtask
  task automatic t_addr;
    int a;
    i_delivery <= 2'h2;
    a = n_acc;
    host_send(8'h5B);
    tick(600);
    chk("tries", n_acc - a, 3);
    chk("drop", n_drop, 1);
    a = n_acc;
    host_send(8'h6C);
    do tick(1); while (n_acc <= a);
    i_rf_collision <= 1'b1;
    tick(1);
    i_rf_collision <= 1'b0;
    do tick(1); while (n_acc <= a + 1);
    i_rf_ack <= 1'b1;
    tick(1);
    i_rf_ack <= 1'b0;
    tick(5);
    chk("resend", n_acc - a, 2);
    chk("acked", n_done, 2);
  endtask
  task automatic t_rx;
    host_pause <= 1'b1;
    tick(5);
    rf_recv(8'hA5, i_dest_mac, i_network_identifier);
    tick(30);
    chk("held", host_cnt, 8'h00);
    chk("held valid", o_host_tx_valid, 0);
    host_pause <= 1'b0;
    tick(40);
    chk("delivered", host_cnt, 8'h01);
    chk("payload", host_last, 8'hA5);
    rf_recv(8'hB6, i_dest_mac, i_network_identifier ^ 8'h01);
    rf_recv(8'hC7, 48'h0000_0000_0009, i_network_identifier);
    tick(40);
    chk("filtered", host_cnt, 8'h01);
  endtask
  task automatic t_fill;
    int a, k;
    a = n_acc;
    k = 0;
    q.delete();
    i_delivery <= 2'h1;
    i_rf_tx_ready <= 1'b0;
    @(posedge i_clk);
    i_host_rx_valid <= 1'b1;
    i_host_rx_data <= 8'h40;
    repeat (8) begin
      @(posedge i_clk);
      if (o_host_rx_ready === 1'b1) begin
        k++;
        i_host_rx_data <= 8'(8'h40 + k);
      end
    end
    i_host_rx_valid <= 1'b0;
    chk("full cts", o_host_cts, 0);
    chk("full ready", o_host_rx_ready, 0);
    i_rf_tx_ready <= 1'b1;
    tick(200);
    chk("drained", n_acc - a, k);
    for (int i = 0; i < k; i++) chk("order", q[i], 8'(8'h40 + i));
    chk("cts back", o_host_cts, 1);
  endtask
  task automatic t_auto;
    rf_recv(8'h11, 48'hA0A0_0000_0001, i_network_identifier);
    tick(3);
    chk("learned", o_dest_learned, 1);
    host_send(8'h22);
    tick(40);
    chk("auto dest", dest_seen, 48'hA0A0_0000_0001);
    tick(500);
  endtask
  task automatic t_bus;
    logic [7:0] c;
    c = host_cnt;
    i_bus_mode <= 1'b1;
    i_delivery <= 2'h0;
    host_pause <= 1'b1;
    host_stall <= 1'b1;
    tick(5);
    rf_recv(8'h77, 48'h0000_0000_0042, i_network_identifier);
    tick(2);
    chk("drive", o_bus_drive, 1);
    chk("bus cts", o_host_cts, 1);
    host_stall <= 1'b0;
    tick(20);
    chk("bus out", host_cnt, 8'(c + 1));
    host_send(8'h99); // bus quiet, host may talk
    tick(150);
    chk("bus in", q[$], 8'h99);
  endtask
  task automatic t_chan;
    logic [7:0] ch [4] = '{8'h0F, 8'h10, 8'h2F, 8'h30};
    int a;
    for (int k = 0; k < 4; k++) begin
      i_channel <= ch[k];
      tick(3);
      chk("chan flag", o_chan_invalid,
        ch[k] < srlc_pkg::CHAN_MIN || ch[k] > srlc_pkg::CHAN_MAX);
    end
    a = n_acc;
    host_send(8'h55);
    tick(60);
    chk("chan block", n_acc - a, 0);
  endtask

  initial begin
    {i_clk, i_bus_mode, i_baud_load, i_crypt_en, i_host_rx_valid, i_rf_ack} = '0;
    {i_rf_collision, i_rf_rx_valid, host_pause, host_stall} = '0;
    {i_sys_rst, i_rts_enable, i_rf_tx_ready} = 3'h7;
    i_baud_div = 16'h0008;
    {i_backoff_spread, i_channel, i_network_identifier, i_max_retries,
      i_bcast_attempts} = 40'h03_10_5A_03_02;
    i_crypt_key = 56'h13_5724_6801_ACE0;
    i_own_mac = 48'h0200_0000_0001;
    i_dest_mac = 48'h0200_0000_0002;
    i_delivery = 2'h0;
    i_host_rx_data = 8'h00;
    {i_rf_rx_data, i_rf_rx_chan, i_rf_rx_netid} = {8'h00, 8'h10, 8'h5A};
    {i_rf_rx_src, i_rf_rx_dst} = {48'h0, 48'h0200_0000_0001};
    repeat (5) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    t_reset;
    t_bcast;
    t_addr;
    t_rx;
    t_fill;
    t_auto;
    t_bus;
    t_chan;
    tally_and_finish;
  end
endmodule
